// *** design/das_consts.svh ***
// Register indices, field positions and reset values of the DMA address and status block
`ifndef DAS_CONSTS_SVH
`define DAS_CONSTS_SVH
`define DAS_IDX_C0_CTRL 12'hfb0
`define DAS_IDX_C0_PTR 12'hfb1
`define DAS_IDX_C0_HI 12'hfb2
`define DAS_IDX_C0_START 12'hfb3
`define DAS_IDX_C0_END 12'hfb4
`define DAS_IDX_C1_CTRL 12'hfb8
`define DAS_IDX_C1_PTR 12'hfb9
`define DAS_IDX_C1_HI 12'hfba
`define DAS_IDX_C1_START 12'hfbb
`define DAS_IDX_C1_END 12'hfbc
`define DAS_IDX_CONV_BASE 12'hfbd
`define DAS_IDX_STATUS 12'hfbf
`define DAS_CTL_EN 0
`define DAS_CTL_WORD 1
`define DAS_STAT_C0 0
`define DAS_STAT_C1 1
`define DAS_STAT_ADC 2
`define DAS_STAT_CUR_LSB 4
`define DAS_RST_REG 8'h00
`define DAS_RST_CTL 2'h0
`define DAS_RST_FLAGS 3'h0
`define DAS_RST_STATUS 8'h00
`define DAS_PERIPH_PAGE 4'hf
`endif

// *** design/das_pkg.sv ***
// Types shared by the DMA address and status block
package das_pkg;
  typedef enum logic [1:0] {
    DAS_SRC_CH0 = 2'b00,
    DAS_SRC_CH1 = 2'b01,
    DAS_SRC_ADC = 2'b10
  } das_src_t;
  typedef enum logic {
    DAS_BUS_IDLE = 1'b0,
    DAS_BUS_RDWAIT = 1'b1
  } das_bus_t;
  typedef struct packed {
    das_src_t src;
    logic word;
    logic [11:0] mem_addr;
    logic [11:0] periph_addr;
  } das_xfer_t;
endpackage : das_pkg

// *** design/das_fifo_if.sv ***
// Valid/ready carrier between the address logic and its record FIFO
`timescale 1ns/1ps
`default_nettype none
interface das_fifo_if #(
  parameter int W = 8
) ();
  logic [W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (
    input in_data,
    input in_valid,
    output in_ready,
    output out_data,
    output out_valid,
    input out_ready
  );
  modport user (
    output in_data,
    output in_valid,
    input in_ready,
    input out_data,
    input out_valid,
    output out_ready
  );
endinterface : das_fifo_if
`default_nettype wire

// *** design/das_fifo.sv ***
// Synchronous FIFO holding transfer records
`timescale 1ns/1ps
`default_nettype none
module das_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  das_fifo_if.fifo f
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = f.in_valid && f.in_ready;
  wire pop = f.out_valid && f.out_ready;
  assign f.in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data = mem_q[rp_q];

  // Explicit wrap so a depth that is not a power of two still works
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= bump(wp_q);
      if (pop) rp_q <= bump(rp_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge hclk) begin
    if (push) mem_q[wp_q] <= f.in_data;
  end
endmodule : das_fifo
`default_nettype wire

// *** design/das_top.sv ***
// DMA address forming and completion status with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "das_consts.svh"
// Functional notes
// - Channel peripheral target fixed to top page
// - End address is end nibble plus low
// - Current address is start nibble plus low
// - Converter address: base, input number, zero
// - Status read clears all three done flags
// - Status shows input under conversion
// - Last converter result sets flag, raises interrupt
// - Channel one end sets flag, raises interrupt
// - Channel zero end sets flag, raises interrupt
module das_top #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [11:0] ADC_DATA_ADDR = 12'h000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] chan_req,
  input wire logic adc_result_valid,
  input wire logic [3:0] adc_result_input,
  input wire logic adc_result_last,
  input wire logic [3:0] adc_busy_input,
  output logic xfer_valid,
  input wire logic xfer_ready,
  output logic [1:0] xfer_src,
  output logic xfer_word,
  output logic [11:0] xfer_mem_addr,
  output logic [11:0] xfer_periph_addr,
  output logic dma_irq
);
  localparam int RW = $bits(das_pkg::das_xfer_t);

  das_fifo_if #(.W(RW)) fq ();

  das_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .f(fq)
  );

  // Bus slave state
  das_pkg::das_bus_t bus_q;
  logic [11:0] idx_q;
  logic wr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_val;

  // Register state
  logic [7:0] ptr_q [2];
  logic [7:0] hi_q [2];
  logic [7:0] slo_q [2];
  logic [7:0] elo_q [2];
  logic [1:0] ctl_q [2];
  logic [7:0] base_q;
  logic [2:0] flag_q;
  logic [3:0] current_input_number_q;
  logic irq_q;

  // Request state
  logic [1:0] pend_q;
  logic adc_pend_q;
  logic [3:0] adc_num_q;
  logic adc_last_q;

  // Output stage
  logic xv_q;
  das_pkg::das_xfer_t xd_q;
  das_pkg::das_xfer_t rec;

  logic [11:0] cur [2];
  logic [11:0] fin [2];
  logic [1:0] serve_ch;
  logic [1:0] done_ch;

  wire acc = hsel && hready && htrans[1];
  wire wr_en = wr_q;
  wire [7:0] wdat = hwdata[7:0];
  wire rd_phase = (bus_q == das_pkg::DAS_BUS_RDWAIT);
  wire stat_rd = rd_phase && (idx_q == `DAS_IDX_STATUS);

  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;

  // Reads take one wait state so that read data leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= das_pkg::DAS_BUS_IDLE;
      idx_q <= 12'h000;
      wr_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        das_pkg::DAS_BUS_IDLE: begin
          wr_q <= acc && hwrite;
          if (acc) idx_q <= haddr[13:2];
          if (acc && !hwrite) begin
            bus_q <= das_pkg::DAS_BUS_RDWAIT;
            hready_q <= 1'b0;
          end
        end
        das_pkg::DAS_BUS_RDWAIT: begin
          wr_q <= 1'b0;
          hrdata_q <= {24'h00_0000, rd_val};
          hready_q <= 1'b1;
          bus_q <= das_pkg::DAS_BUS_IDLE;
        end
      endcase
    end
  end

  wire [7:0] stat_val = {current_input_number_q, 1'b0, flag_q};
  assign rd_val =
    (idx_q == `DAS_IDX_C0_CTRL) ? {6'h00, ctl_q[0]} :
    (idx_q == `DAS_IDX_C0_PTR) ? ptr_q[0] :
    (idx_q == `DAS_IDX_C0_HI) ? hi_q[0] :
    (idx_q == `DAS_IDX_C0_START) ? slo_q[0] :
    (idx_q == `DAS_IDX_C0_END) ? elo_q[0] :
    (idx_q == `DAS_IDX_C1_CTRL) ? {6'h00, ctl_q[1]} :
    (idx_q == `DAS_IDX_C1_PTR) ? ptr_q[1] :
    (idx_q == `DAS_IDX_C1_HI) ? hi_q[1] :
    (idx_q == `DAS_IDX_C1_START) ? slo_q[1] :
    (idx_q == `DAS_IDX_C1_END) ? elo_q[1] :
    (idx_q == `DAS_IDX_CONV_BASE) ? base_q :
    (idx_q == `DAS_IDX_STATUS) ? stat_val :
    8'h00;

  // Per-channel address registers
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam logic [11:0] ICTL = (ch == 0) ? `DAS_IDX_C0_CTRL : `DAS_IDX_C1_CTRL;
    localparam logic [11:0] IPTR = (ch == 0) ? `DAS_IDX_C0_PTR : `DAS_IDX_C1_PTR;
    localparam logic [11:0] IHI = (ch == 0) ? `DAS_IDX_C0_HI : `DAS_IDX_C1_HI;
    localparam logic [11:0] ISTA = (ch == 0) ? `DAS_IDX_C0_START : `DAS_IDX_C1_START;
    localparam logic [11:0] IEND = (ch == 0) ? `DAS_IDX_C0_END : `DAS_IDX_C1_END;
    wire wr_ctl = wr_en && (idx_q == ICTL);
    wire wr_ptr = wr_en && (idx_q == IPTR);
    wire wr_hi = wr_en && (idx_q == IHI);
    wire wr_sta = wr_en && (idx_q == ISTA);
    wire wr_end = wr_en && (idx_q == IEND);
    wire adv = serve_ch[ch] && !wr_hi && !wr_sta;
    wire word = ctl_q[ch][`DAS_CTL_WORD];
    wire [11:0] cur_p1 = cur[ch] + 12'h001;
    wire [11:0] nxt = word ? (cur[ch] + 12'h002) : cur_p1;
    assign cur[ch] = {hi_q[ch][3:0], slo_q[ch]};
    assign fin[ch] = {hi_q[ch][7:4], elo_q[ch]};
    // A word transfer whose second byte hits the end address also finishes
    assign done_ch[ch] = serve_ch[ch] && ((cur[ch] == fin[ch]) || (word && cur_p1 == fin[ch]));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ptr_q[ch] <= `DAS_RST_REG;
        hi_q[ch] <= `DAS_RST_REG;
        slo_q[ch] <= `DAS_RST_REG;
        elo_q[ch] <= `DAS_RST_REG;
        ctl_q[ch] <= `DAS_RST_CTL;
      end else begin
        if (wr_ptr) ptr_q[ch] <= wdat;
        if (wr_end) elo_q[ch] <= wdat;
        if (wr_hi) hi_q[ch] <= wdat;
        else if (adv) hi_q[ch][3:0] <= nxt[11:8];
        if (wr_sta) slo_q[ch] <= wdat;
        else if (adv) slo_q[ch] <= nxt[7:0];
        if (wr_ctl) ctl_q[ch] <= wdat[1:0];
        else if (done_ch[ch]) ctl_q[ch][`DAS_CTL_EN] <= 1'b0;
      end
    end
  end

  // Converter first, then channel zero, then channel one
  wire [1:0] ch_en = {ctl_q[1][`DAS_CTL_EN], ctl_q[0][`DAS_CTL_EN]};
  wire chi = !pend_q[0];
  wire serve_adc = fq.in_ready && adc_pend_q;
  assign serve_ch[0] = fq.in_ready && !adc_pend_q && pend_q[0];
  assign serve_ch[1] = fq.in_ready && !adc_pend_q && !pend_q[0] && pend_q[1];
  wire [1:0] pend_d = (pend_q & ~serve_ch) | (chan_req & ch_en);

  assign rec.src = adc_pend_q ? das_pkg::DAS_SRC_ADC
                 : (pend_q[0] ? das_pkg::DAS_SRC_CH0 : das_pkg::DAS_SRC_CH1);
  assign rec.word = adc_pend_q ? 1'b1 : ctl_q[chi][`DAS_CTL_WORD];
  // Base bit 0 is ignored; each input owns two bytes
  assign rec.mem_addr = adc_pend_q ? {base_q[7:1], adc_num_q, 1'b0} : cur[chi];
  // Channels only ever reach the top register page
  assign rec.periph_addr = adc_pend_q ? ADC_DATA_ADDR
                         : {`DAS_PERIPH_PAGE, ptr_q[chi]};
  assign fq.in_data = rec;
  assign fq.in_valid = adc_pend_q || (pend_q != 2'b00);

  wire [2:0] flag_set = {serve_adc && adc_last_q, done_ch[1], done_ch[0]};
  // A completion landing on the clearing read survives it
  wire [2:0] flag_d = flag_set | (flag_q & {3{!stat_rd}});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_q <= `DAS_RST_REG;
      flag_q <= `DAS_RST_FLAGS;
      irq_q <= 1'b0;
      current_input_number_q <= 4'h0;
      pend_q <= 2'b00;
    end else begin
      if (wr_en && idx_q == `DAS_IDX_CONV_BASE) base_q <= wdat;
      flag_q <= flag_d;
      irq_q <= |flag_d;
      current_input_number_q <= adc_busy_input;
      pend_q <= pend_d;
    end
  end

  // One result is held; a second before service replaces it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_pend_q <= 1'b0;
      adc_num_q <= 4'h0;
      adc_last_q <= 1'b0;
    end else if (adc_result_valid) begin
      adc_pend_q <= 1'b1;
      adc_num_q <= adc_result_input;
      adc_last_q <= adc_result_last;
    end else if (serve_adc) begin
      adc_pend_q <= 1'b0;
    end
  end

  assign fq.out_ready = !xv_q || xfer_ready;
  wire pop = fq.out_valid && fq.out_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xv_q <= 1'b0;
      xd_q <= '0;
    end else if (pop) begin
      xv_q <= 1'b1;
      xd_q <= das_pkg::das_xfer_t'(fq.out_data);
    end else if (xfer_ready) begin
      xv_q <= 1'b0;
    end
  end

  assign xfer_valid = xv_q;
  assign xfer_src = xd_q.src;
  assign xfer_word = xd_q.word;
  assign xfer_mem_addr = xd_q.mem_addr;
  assign xfer_periph_addr = xd_q.periph_addr;
  assign dma_irq = irq_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_stat_read;
    stat_rd;
  endsequence
  sequence s_flags_cleared;
    ##1 ((flag_q & ~$past(flag_set)) == 3'b000) && (hrdata_q[2:0] == $past(flag_q));
  endsequence

  chk_periph_page: assert property (
    xfer_valid && xfer_src != das_pkg::DAS_SRC_ADC |-> xfer_periph_addr[11:8] == 4'hf)
    else $error("Channel peripheral address left the top page");

  chk_end_nibble: assert property (
    wr_en && idx_q == `DAS_IDX_C0_HI |=> fin[0] == {$past(wdat[7:4]), $past(elo_q[0])})
    else $error("End address not formed from high nibble and low byte");

  chk_start_nibble: assert property (
    wr_en && idx_q == `DAS_IDX_C0_START |=> cur[0] == {$past(hi_q[0][3:0]), $past(wdat)})
    else $error("Current address not formed from high nibble and low byte");

  chk_conv_addr: assert property (
    serve_adc |-> rec.mem_addr[11:5] == base_q[7:1] && rec.mem_addr[4:1] == adc_num_q
      && !rec.mem_addr[0])
    else $error("Converter result address malformed");

  chk_conv_even: assert property (
    xfer_valid && xfer_src == das_pkg::DAS_SRC_ADC |-> !xfer_mem_addr[0] && xfer_word)
    else $error("Converter record not an even word address");

  chk_status_clear: assert property (
    s_stat_read |-> s_flags_cleared)
    else $error("Status read did not return then clear the flags");

  chk_input_shown: assert property (
    stat_rd |=> hrdata_q[7:4] == $past(adc_busy_input, 2))
    else $error("Status does not show the converting input");

  chk_conv_done: assert property (
    serve_adc && adc_last_q |=> flag_q[`DAS_STAT_ADC] && dma_irq)
    else $error("Last converter result did not flag and interrupt");

  chk_ch1_done: assert property (
    done_ch[1] |=> flag_q[`DAS_STAT_C1] && dma_irq)
    else $error("Channel one end did not flag and interrupt");

  chk_ch0_done: assert property (
    done_ch[0] |=> flag_q[`DAS_STAT_C0] && dma_irq)
    else $error("Channel zero end did not flag and interrupt");

  chk_addr_advance: assert property (
    serve_ch[0] && !wr_en |=> cur[0] == $past(cur[0])
      + ($past(ctl_q[0][`DAS_CTL_WORD]) ? 12'h002 : 12'h001))
    else $error("Channel zero address did not advance");

  chk_end_stops: assert property (
    done_ch[0] && !wr_en |=> !ctl_q[0][`DAS_CTL_EN])
    else $error("Channel zero still enabled after its end address");
endmodule : das_top
`default_nettype wire

// *** test/das_far_model.sv ***
// Far side model: converter result source and transfer record consumer
`timescale 1ns/1ps
`default_nettype none
module das_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stall,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [26:0] rec,
  output logic adc_result_valid,
  output logic [3:0] adc_result_input,
  output logic adc_result_last,
  output logic [3:0] adc_busy_input
);
  logic [26:0] got[$];
  // Ready ignores valid, so the block cannot lean on a combinational reply
  assign xfer_ready = !stall;
  always @(posedge hclk) begin
    if (hresetn && xfer_valid && xfer_ready) begin
      got.push_back(rec);
    end
  end
  initial begin
    adc_result_valid = 1'b0;
    adc_result_input = 4'h0;
    adc_result_last = 1'b0;
    adc_busy_input = 4'h0;
  end
  // Qualifiers are scrambled after the pulse so stale values cannot pass
  task automatic result(input logic [3:0] n, input logic l);
    @(posedge hclk);
    adc_result_valid <= 1'b1;
    adc_result_input <= n;
    adc_result_last <= l;
    @(posedge hclk);
    adc_result_valid <= 1'b0;
    adc_result_input <= ~n;
    adc_result_last <= ~l;
  endtask : result
  task automatic set_busy(input logic [3:0] n);
    @(posedge hclk);
    adc_busy_input <= n;
  endtask : set_busy
endmodule : das_far_model
`default_nettype wire

// *** test/das_top_tb.sv ***
// Self-checking bench for the DMA address and status block
`timescale 1ns/1ps
`default_nettype none
`include "das_consts.svh"
module das_top_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, stall;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, chan_req, xfer_src;
  logic avalid, alast, xfer_valid, xfer_ready, xfer_word, dma_irq;
  logic [3:0] ainput, abusy;
  logic [11:0] xfer_mem_addr, xfer_periph_addr;
  logic [26:0] rec;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  assign rec = {xfer_src, xfer_word, xfer_mem_addr, xfer_periph_addr};
  das_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .chan_req(chan_req),
    .adc_result_valid(avalid), .adc_result_input(ainput), .adc_result_last(alast),
    .adc_busy_input(abusy), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
    .xfer_src(xfer_src), .xfer_word(xfer_word), .xfer_mem_addr(xfer_mem_addr),
    .xfer_periph_addr(xfer_periph_addr), .dma_irq(dma_irq));
  das_far_model u_far (.hclk(hclk), .hresetn(hresetn), .stall(stall),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .rec(rec), .adc_result_valid(avalid),
    .adc_result_input(ainput), .adc_result_last(alast), .adc_busy_input(abusy));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // The whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic [11:0] ix, input logic w, input logic [7:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, ix, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] ix, input logic [7:0] d);
    logic [31:0] r;
    bus(ix, 1'b1, d, r);
  endtask : wr
  task automatic rdc(input logic [11:0] ix, input logic [7:0] e);
    logic [31:0] r;
    bus(ix, 1'b0, 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rdc
  task automatic req(input int ch);
    @(posedge hclk);
    chan_req <= 2'(1 << ch);
    @(posedge hclk);
    chan_req <= 2'b00;
  endtask : req
  task automatic pop(input logic [26:0] e);
    int k;
    logic [26:0] v;
    k = 0;
    while (u_far.got.size() == 0 && k < 100) begin
      @(posedge hclk);
      k++;
    end
    v = (u_far.got.size() > 0) ? u_far.got.pop_front() : 27'h0;
    chk({5'h0, v}, {5'h0, e});
  endtask : pop
  task automatic setup(input logic [11:0] b, input logic [7:0] p, input logic [7:0] h,
                       input logic [7:0] s, input logic [7:0] e, input logic [7:0] c);
    wr(b + 12'h1, p);
    wr(b + 12'h2, h);
    wr(b + 12'h3, s);
    wr(b + 12'h4, e);
    wr(b, c);
  endtask : setup
  task automatic t_regs;
    logic [11:0] ix[6];
    ix = '{`DAS_IDX_C0_PTR, `DAS_IDX_C0_HI, `DAS_IDX_C1_PTR, `DAS_IDX_C1_HI,
           `DAS_IDX_CONV_BASE, `DAS_IDX_STATUS};
    foreach (ix[i]) rdc(ix[i], 8'h00);
    foreach (ix[i]) wr(ix[i], 8'ha4 + 8'(i));
    for (int i = 0; i < 5; i++) rdc(ix[i], 8'ha4 + 8'(i));
    rdc(`DAS_IDX_STATUS, 8'h00);
    wr(12'hfb5, 8'hff);
    rdc(12'hfb5, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ch0;
    setup(`DAS_IDX_C0_CTRL, 8'h34, 8'h21, 8'hfe, 8'h00, 8'h01);
    req(0);
    req(0);
    pop({2'b00, 1'b0, 12'h1fe, 12'hf34});
    pop({2'b00, 1'b0, 12'h1ff, 12'hf34});
    repeat (3) @(posedge hclk);
    chk({31'h0, dma_irq}, 32'h0);
    req(0);
    pop({2'b00, 1'b0, 12'h200, 12'hf34});
    repeat (3) @(posedge hclk);
    chk({31'h0, dma_irq}, 32'h1);
    rdc(`DAS_IDX_C0_CTRL, 8'h00);
    req(0);
    repeat (6) @(posedge hclk);
    chk(u_far.got.size(), 0);
    $display("test ch0 done");
  endtask : t_ch0
  task automatic t_ch1;
    setup(`DAS_IDX_C1_CTRL, 8'h40, 8'h00, 8'h10, 8'h12, 8'h03);
    req(1);
    req(1);
    pop({2'b01, 1'b1, 12'h010, 12'hf40});
    pop({2'b01, 1'b1, 12'h012, 12'hf40});
    rdc(`DAS_IDX_C1_CTRL, 8'h02);
    wr(`DAS_IDX_C1_START, 8'h20);
    wr(`DAS_IDX_C1_END, 8'h23);
    wr(`DAS_IDX_C1_CTRL, 8'h03);
    req(1);
    req(1);
    pop({2'b01, 1'b1, 12'h020, 12'hf40});
    pop({2'b01, 1'b1, 12'h022, 12'hf40});
    rdc(`DAS_IDX_C1_CTRL, 8'h02);
    $display("test ch1 done");
  endtask : t_ch1
  task automatic t_conv;
    wr(`DAS_IDX_CONV_BASE, 8'h72);
    u_far.set_busy(4'h5);
    u_far.result(4'h3, 1'b0);
    pop({2'b10, 1'b1, 12'h726, 12'h000});
    repeat (3) @(posedge hclk);
    rdc(`DAS_IDX_STATUS, 8'h53);
    u_far.result(4'hb, 1'b1);
    pop({2'b10, 1'b1, 12'h736, 12'h000});
    repeat (3) @(posedge hclk);
    chk({31'h0, dma_irq}, 32'h1);
    rdc(`DAS_IDX_STATUS, 8'h54);
    rdc(`DAS_IDX_STATUS, 8'h50);
    repeat (2) @(posedge hclk);
    chk({31'h0, dma_irq}, 32'h0);
    $display("test conv done");
  endtask : t_conv
  task automatic t_fill;
    stall <= 1'b1;
    setup(`DAS_IDX_C0_CTRL, 8'h10, 8'h33, 8'h00, 8'hff, 8'h01);
    for (int i = 0; i < 5; i++) begin
      req(0);
      repeat (2) @(posedge hclk);
    end
    chk({31'h0, xfer_valid}, 32'h1);
    chk({20'h0, xfer_mem_addr}, 32'h300);
    chk(u_far.got.size(), 0);
    stall <= 1'b0;
    for (int i = 0; i < 5; i++) pop({2'b00, 1'b0, 12'h300 + 12'(i), 12'hf10});
    repeat (2) @(posedge hclk);
    chk({31'h0, xfer_valid}, 32'h0);
    rdc(`DAS_IDX_C0_CTRL, 8'h01);
    $display("test fill done");
  endtask : t_fill
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    chan_req = 2'b00;
    stall = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({29'h0, hresp, dma_irq, hreadyout}, 32'h1);
    t_regs();
    t_ch0();
    t_ch1();
    t_conv();
    t_fill();
    complete_run();
  end
endmodule : das_top_tb
`default_nettype wire
